// ---- fsr_map.vh ----
`ifndef FSR_MAP_VH
`define FSR_MAP_VH
// Function
// - Reserved bits read zero and are never changed by a clear.
// - Second-level overtemperature sets thermal bit 2 and forces fail-safe.
// - First-level overtemperature sets thermal bit 1.
// - Temperature pre-warning sets thermal bit 0.
// - Thermal flags stay set until clear or reset.
// - Previous-state bits 7:6: 00 cleared, 01 failure, 10 sleep, 11 reserved.
// - Watchdog, shutdown, undervoltage, optional overvoltage, bad sleep, fail-safe wake record 01.
// - Sleep attempt with wake flags uncleared records 10.
// - Bits 3:2 count watchdog failures; only field hardware clears itself.
// - Counter clears on good watchdog trigger and on watchdog stop.
// - Stop in sleep or fail-safe keeps counter if entered by watchdog failure.
// - Configurations 2 and 4 freeze counter after failure until good trigger or watchdog stop.
// - Invalid SPI command sets device status bit 1.
// - Command-error flag clears only by host clear command or reset.
// - Fail output activation sets device status bit 0.
// - Configuration 0: first watchdog failure only restarts, no fail output.
// - LIN code bits 6:5: none, shutdown, transmit stuck, line stuck over 20ms.
// - CAN code bits 2:1: none, shutdown, transmit stuck, line stuck.
// - CAN supply low sets bus bit 0 and disables CAN transmitter.
// - CAN supply comparator active only while CAN mode bit is one.
// - Bit 7 one clears addressed register's clearable bits as a byte.
// - Only the watchdog counter clears without host command.
`define FSR_ADDR_THERM 7'h42
`define FSR_ADDR_DEV 7'h43
`define FSR_ADDR_BUS 7'h44
`define FSR_RESET_VAL 8'h00
`define FSR_THERM_MASK 8'h07
`define FSR_DEV_CLR_MASK 8'hC3
`define FSR_BUS_MASK 8'h67
`define FSR_PREV_CLEARED 2'h0
`define FSR_PREV_FAILURE 2'h1
`define FSR_PREV_SLEEP 2'h2
`define FSR_CODE_NONE 2'h0
`define FSR_CODE_TSD 2'h1
`define FSR_CODE_TXD 2'h2
`define FSR_CODE_BUS 2'h3
`define FSR_LIN_TO_MS 20
`define FSR_CLK_KHZ 50000
`define FSR_LIN_TO_CYC (`FSR_LIN_TO_MS * `FSR_CLK_KHZ)
`endif

// ---- fsr_dom_timer.v ----
`timescale 1ns/1ps
`include "fsr_map.vh"
module fsr_dom_timer #(
  parameter LIMIT = `FSR_LIN_TO_CYC,
  parameter WIDTH = 24
) (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Level watched and timeout pulse
  input wire dominant,
  output reg timeout
);
  reg [WIDTH-1:0] count;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= {WIDTH{1'b0}};
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      if (!dominant) begin
        count <= {WIDTH{1'b0}};
      end else if (count == LIMIT[WIDTH-1:0] - 1'b1) begin
        timeout <= 1'b1;
        count <= count + 1'b1;
      end else if (count != {WIDTH{1'b1}}) begin
        count <= count + 1'b1;
      end
    end
  end
endmodule // fsr_dom_timer

// ---- fsr_wd_counter.v ----
`timescale 1ns/1ps
module fsr_wd_counter (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Watchdog events
  input wire wdFail,
  input wire wdGoodTrigger,
  input wire wdStop,
  input wire stopAfterWdFail,
  input wire cfgFreeze,
  // Count
  output reg [1:0] count
);
  reg frozen;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 2'h0;
      frozen <= 1'b0;
    end else if (wdGoodTrigger) begin
      count <= 2'h0;
      frozen <= 1'b0;
    end else if (wdStop && !stopAfterWdFail) begin
      count <= 2'h0;
      frozen <= 1'b0;
    end else if (wdFail && !frozen) begin
      if (count != 2'h3) begin
        count <= count + 2'h1;
      end
      frozen <= cfgFreeze;
    end
  end
endmodule // fsr_wd_counter

// ---- fsr_status_bank.v ----
`timescale 1ns/1ps
`include "fsr_map.vh"
module fsr_status_bank #(
  parameter LIN_TIMEOUT_CYC = `FSR_LIN_TO_CYC,
  parameter CAN_TXD_TIMEOUT_CYC = `FSR_LIN_TO_CYC,
  parameter CAN_BUS_TIMEOUT_CYC = `FSR_LIN_TO_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  input wire softReset,
  // Host access, one decoded 16-bit frame
  input wire frameValid,
  input wire [6:0] frameAddr,
  input wire frameClear,
  output reg [7:0] readData,
  output reg readValid,
  // Thermal events
  input wire overtempSecond,
  input wire overtempFirst,
  input wire thermalPrewarn,
  // Device history events
  input wire restartFailure,
  input wire supplyOvervolt,
  input wire mainSupplyOvervoltRestartOption,
  input wire sleepEntryFailure,
  input wire sleepWakeFlagsPending,
  input wire invalidCommand,
  input wire failOutputActivate,
  input wire wdFail,
  input wire wdGoodTrigger,
  input wire wdStop,
  input wire stopAfterWdFail,
  input wire [2:0] configSelect,
  // Bus transceiver events
  input wire linThermalShutdown,
  input wire linTxDominant,
  input wire linBusDominant,
  input wire canThermalShutdown,
  input wire canTxDominant,
  input wire canBusDominant,
  input wire canSupplyLow,
  input wire canModeBit,
  // Effects
  output reg failSafeRequest,
  output reg canTransmitDisable,
  output reg failOutputPin,
  // Register views
  output reg [7:0] thermalFaultStatus,
  output reg [7:0] deviceHistoryStatus,
  output reg [7:0] busTransceiverFaultStatus
);
  reg [2:0] thermFlags;
  reg [1:0] previousStateField;
  reg commandError;
  reg failFlag;
  reg [1:0] linFaultCode;
  reg [1:0] canFaultCode;
  reg canSupplyLowFlag;
  reg firstWdFailSeen;
  wire [1:0] watchdogMissCounter;
  wire linTxTimeout;
  wire linBusTimeout;
  wire canTxTimeout;
  wire canBusTimeout;
  wire clrTherm;
  wire clrDev;
  wire clrBus;
  wire cfgFreeze;
  wire failCause;
  wire wdFailSilent;
  wire failSet;
  wire canUvEvent;
  reg [1:0] next_linCode;
  reg [1:0] next_canCode;

  function isClear;
    input valid;
    input clr;
    input [6:0] addr;
    input [6:0] target;
    begin
      isClear = valid && clr && (addr == target);
    end
  endfunction

  assign clrTherm = isClear(frameValid, frameClear, frameAddr, `FSR_ADDR_THERM);
  assign clrDev = isClear(frameValid, frameClear, frameAddr, `FSR_ADDR_DEV);
  assign clrBus = isClear(frameValid, frameClear, frameAddr, `FSR_ADDR_BUS);
  assign cfgFreeze = (configSelect == 3'h2) || (configSelect == 3'h4);
  assign failCause = restartFailure || wdFail || overtempSecond || sleepEntryFailure ||
    (supplyOvervolt && mainSupplyOvervoltRestartOption);
  assign wdFailSilent = wdFail && (configSelect == 3'h0) && !firstWdFailSeen;
  assign failSet = failOutputActivate || (wdFail && !wdFailSilent);
  assign canUvEvent = canSupplyLow && canModeBit;

  fsr_dom_timer #(.LIMIT(LIN_TIMEOUT_CYC), .WIDTH(24)) linTxTimer (
    .ref_clk(ref_clk), .arst_n(arst_n), .dominant(linTxDominant), .timeout(linTxTimeout));
  fsr_dom_timer #(.LIMIT(LIN_TIMEOUT_CYC), .WIDTH(24)) linBusTimer (
    .ref_clk(ref_clk), .arst_n(arst_n), .dominant(linBusDominant), .timeout(linBusTimeout));
  fsr_dom_timer #(.LIMIT(CAN_TXD_TIMEOUT_CYC), .WIDTH(24)) canTxTimer (
    .ref_clk(ref_clk), .arst_n(arst_n), .dominant(canTxDominant), .timeout(canTxTimeout));
  fsr_dom_timer #(.LIMIT(CAN_BUS_TIMEOUT_CYC), .WIDTH(24)) canBusTimer (
    .ref_clk(ref_clk), .arst_n(arst_n), .dominant(canBusDominant), .timeout(canBusTimeout));

  fsr_wd_counter wdCount (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wdFail(wdFail),
    .wdGoodTrigger(wdGoodTrigger),
    .wdStop(wdStop),
    .stopAfterWdFail(stopAfterWdFail),
    .cfgFreeze(cfgFreeze),
    .count(watchdogMissCounter)
  );

  // Highest-severity event of the cycle wins and overwrites the stored code; new event beats clear
  always @* begin
    next_linCode = clrBus ? `FSR_CODE_NONE : linFaultCode;
    if (linBusTimeout) begin
      next_linCode = `FSR_CODE_BUS;
    end else if (linTxTimeout) begin
      next_linCode = `FSR_CODE_TXD;
    end else if (linThermalShutdown) begin
      next_linCode = `FSR_CODE_TSD;
    end
    next_canCode = clrBus ? `FSR_CODE_NONE : canFaultCode;
    if (canBusTimeout) begin
      next_canCode = `FSR_CODE_BUS;
    end else if (canTxTimeout) begin
      next_canCode = `FSR_CODE_TXD;
    end else if (canThermalShutdown) begin
      next_canCode = `FSR_CODE_TSD;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      thermFlags <= 3'h0;
      previousStateField <= `FSR_PREV_CLEARED;
      commandError <= 1'b0;
      failFlag <= 1'b0;
      linFaultCode <= `FSR_CODE_NONE;
      canFaultCode <= `FSR_CODE_NONE;
      canSupplyLowFlag <= 1'b0;
      firstWdFailSeen <= 1'b0;
    end else if (softReset) begin
      thermFlags <= 3'h0;
      previousStateField <= `FSR_PREV_CLEARED;
      commandError <= 1'b0;
      failFlag <= 1'b0;
      linFaultCode <= `FSR_CODE_NONE;
      canFaultCode <= `FSR_CODE_NONE;
      canSupplyLowFlag <= 1'b0;
      firstWdFailSeen <= 1'b0;
    end else begin
      // Sticky: only host clear drops a flag
      thermFlags[2] <= overtempSecond | (thermFlags[2] & ~clrTherm);
      thermFlags[1] <= overtempFirst | (thermFlags[1] & ~clrTherm);
      thermFlags[0] <= thermalPrewarn | (thermFlags[0] & ~clrTherm);
      if (failCause) begin
        previousStateField <= `FSR_PREV_FAILURE;
      end else if (sleepWakeFlagsPending) begin
        previousStateField <= `FSR_PREV_SLEEP;
      end else if (clrDev) begin
        previousStateField <= `FSR_PREV_CLEARED;
      end
      commandError <= invalidCommand | (commandError & ~clrDev);
      failFlag <= failSet | (failFlag & ~clrDev);
      if (wdFail) begin
        firstWdFailSeen <= 1'b1;
      end else if (wdGoodTrigger) begin
        firstWdFailSeen <= 1'b0;
      end
      linFaultCode <= next_linCode;
      canFaultCode <= next_canCode;
      canSupplyLowFlag <= canUvEvent | (canSupplyLowFlag & ~clrBus);
    end
  end

  // Registered outputs and read port
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      thermalFaultStatus <= `FSR_RESET_VAL;
      deviceHistoryStatus <= `FSR_RESET_VAL;
      busTransceiverFaultStatus <= `FSR_RESET_VAL;
      readData <= 8'h00;
      readValid <= 1'b0;
      failSafeRequest <= 1'b0;
      canTransmitDisable <= 1'b0;
      failOutputPin <= 1'b0;
    end else begin
      thermalFaultStatus <= {5'h00, thermFlags};
      deviceHistoryStatus <= {previousStateField, 2'h0, watchdogMissCounter, commandError, failFlag};
      busTransceiverFaultStatus <= {1'b0, linFaultCode, 2'h0, canFaultCode, canSupplyLowFlag};
      failSafeRequest <= overtempSecond;
      canTransmitDisable <= canUvEvent;
      failOutputPin <= failSet;
      readValid <= frameValid;
      if (!frameValid) begin
        readData <= 8'h00;
      end else if (frameAddr == `FSR_ADDR_THERM) begin
        readData <= {5'h00, thermFlags};
      end else if (frameAddr == `FSR_ADDR_DEV) begin
        readData <= {previousStateField, 2'h0, watchdogMissCounter, commandError, failFlag};
      end else if (frameAddr == `FSR_ADDR_BUS) begin
        readData <= {1'b0, linFaultCode, 2'h0, canFaultCode, canSupplyLowFlag};
      end else begin
        readData <= 8'h00;
      end
    end
  end
endmodule // fsr_status_bank

// ---- fsr_status_bank_asserts.sv ----
`timescale 1ns/1ps
module fsr_status_bank_asserts (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  input wire softReset,
  // Host frame and events
  input wire frameValid,
  input wire [6:0] frameAddr,
  input wire frameClear,
  input wire overtempSecond,
  input wire thermalPrewarn,
  input wire invalidCommand,
  input wire canSupplyLow,
  input wire canModeBit,
  // Outputs
  input wire readValid,
  input wire failSafeRequest,
  input wire [7:0] thermalFaultStatus,
  input wire [7:0] deviceHistoryStatus,
  input wire [7:0] busTransceiverFaultStatus
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire thClr = frameValid && frameClear && frameAddr == 7'h42;
  property p_resv;
    ((thermalFaultStatus & 8'hF8) | (deviceHistoryStatus & 8'h30) | (busTransceiverFaultStatus & 8'h98)) == 8'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_rdlat; frameValid |=> readValid; endproperty
  a_rdlat: assert property (p_rdlat) else $error("no answer to frame");
  property p_overtemp_shutdown_second; overtempSecond && !softReset |=> failSafeRequest ##1 thermalFaultStatus[2]; endproperty
  a_overtemp_shutdown_second: assert property (p_overtemp_shutdown_second) else $error("shutdown flag or fail-safe missing");
  property p_cmderr; invalidCommand && !softReset |-> ##2 deviceHistoryStatus[1]; endproperty
  a_cmderr: assert property (p_cmderr) else $error("command error flag missing");
  property p_sticky;
    |($past(thermalFaultStatus[2:0]) & ~thermalFaultStatus[2:0]) |-> $past(thClr, 2) || $past(softReset, 2);
  endproperty
  a_sticky: assert property (p_sticky) else $error("thermal flag dropped");
  property p_collide; thClr && thermalPrewarn |-> ##2 thermalFaultStatus[0]; endproperty
  a_collide: assert property (p_collide) else $error("event lost on clear");
  property p_canuv; canSupplyLow && canModeBit |-> ##2 busTransceiverFaultStatus[0]; endproperty
  a_canuv: assert property (p_canuv) else $error("supply low flag missing");
  property p_cangate; $rose(busTransceiverFaultStatus[0]) |-> $past(canSupplyLow && canModeBit, 2); endproperty
  a_cangate: assert property (p_cangate) else $error("supply low flag without cause");
endmodule // fsr_status_bank_asserts
bind fsr_status_bank fsr_status_bank_asserts chk (.*);

// ---- fsr_host_model.sv ----
`timescale 1ns/1ps
module fsr_host_model (
  // Clock
  input wire ref_clk,
  // Frame toward the bank
  output logic frameValid,
  output logic [6:0] frameAddr,
  output logic frameClear,
  // Answer
  input wire [7:0] readData,
  input wire readValid
);
  initial begin
    frameValid = 1'b0;
    frameAddr = 7'h00;
    frameClear = 1'b0;
  end
  task automatic xfer(input [6:0] a, input c, output [7:0] d, output ok);
    @(posedge ref_clk);
    #1;
    frameValid = 1'b1;
    frameAddr = a;
    frameClear = c;
    @(posedge ref_clk);
    #1;
    d = readData;
    ok = readValid;
    frameValid = 1'b0;
    // Released lines show the inverse
    frameAddr = ~a;
    frameClear = ~c;
  endtask
endmodule // fsr_host_model

// ---- tb_fault_status_registers.sv ----
`timescale 1ns/1ps
`include "fsr_map.vh"
module tb_fault_status_registers;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic softReset = 1'b0;
  logic [2:0] th = 3'h0;
  logic [5:0] dv = 6'h00;
  logic [2:0] wd = 3'h0;
  logic [5:0] bv = 6'h00;
  logic [2:0] cfg = 3'h1;
  logic ovOpt = 1'b0;
  logic stopWd = 1'b0;
  logic canLow = 1'b0;
  logic canMode = 1'b0;
  wire frameValid, frameClear, readValid, canTxOff, failPin;
  wire [6:0] frameAddr;
  wire [7:0] readData;
  int err_total = 0;
  int checks = 0;
  logic [7:0] d;
  logic ok;
  logic [1:0] c;
  initial forever #10 ref_clk = ~ref_clk;
  fsr_host_model host (.ref_clk(ref_clk), .frameValid(frameValid), .frameAddr(frameAddr),
    .frameClear(frameClear), .readData(readData), .readValid(readValid));
  fsr_status_bank #(.LIN_TIMEOUT_CYC(10), .CAN_TXD_TIMEOUT_CYC(10), .CAN_BUS_TIMEOUT_CYC(10)) uut (
    .ref_clk(ref_clk), .arst_n(arst_n), .softReset(softReset), .frameValid(frameValid),
    .frameAddr(frameAddr), .frameClear(frameClear), .readData(readData), .readValid(readValid),
    .overtempSecond(th[2]), .overtempFirst(th[1]), .thermalPrewarn(th[0]), .restartFailure(dv[0]),
    .supplyOvervolt(dv[1]), .mainSupplyOvervoltRestartOption(ovOpt), .sleepEntryFailure(dv[2]),
    .sleepWakeFlagsPending(dv[3]), .invalidCommand(dv[4]), .failOutputActivate(dv[5]), .wdFail(wd[0]),
    .wdGoodTrigger(wd[1]), .wdStop(wd[2]), .stopAfterWdFail(stopWd), .configSelect(cfg),
    .linThermalShutdown(bv[0]), .linTxDominant(bv[1]), .linBusDominant(bv[2]), .canThermalShutdown(bv[3]),
    .canTxDominant(bv[4]), .canBusDominant(bv[5]), .canSupplyLow(canLow), .canModeBit(canMode),
    .failSafeRequest(), .canTransmitDisable(canTxOff), .failOutputPin(failPin), .thermalFaultStatus(),
    .deviceHistoryStatus(), .busTransceiverFaultStatus());
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input [7:0] got, input [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input [6:0] a, input cl, input [7:0] m, input [7:0] e);
    host.xfer(a, cl, d, ok);
    chk(d & m, e);
    chk({7'h00, ok}, 8'h01);
  endtask
  task automatic dev(input [5:0] v, input [7:0] e);
    dv = v;
    tick(1);
    dv = 6'h00;
    rd(`FSR_ADDR_DEV, 1'b1, 8'hFF, e);
  endtask
  task automatic wp(input [2:0] v);
    wd = v;
    tick(1);
    wd = 3'h0;
    tick(1);
  endtask
  task summarize;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    summarize;
  end
  initial begin
    tick(8);
    arst_n = 1'b1;
    for (int a = 'h42; a < 'h46; a++) rd(a[6:0], 1'b0, 8'hFF, 8'h00);
    rd(7'h7F, 1'b1, 8'hFF, 8'h00);
    th = 3'h7;
    tick(1);
    th = 3'h0;
    rd(`FSR_ADDR_THERM, 1'b0, 8'hFF, 8'h07);
    rd(`FSR_ADDR_THERM, 1'b1, 8'hFF, 8'h07);
    th = 3'h1;
    rd(`FSR_ADDR_THERM, 1'b1, 8'hFF, 8'h01);
    th = 3'h0;
    rd(`FSR_ADDR_THERM, 1'b1, 8'hFF, 8'h01);
    rd(`FSR_ADDR_THERM, 1'b0, 8'hFF, 8'h00);
    dev(6'h31, 8'h43);
    dev(6'h08, 8'h80);
    dev(6'h0C, 8'h40);
    dev(6'h02, 8'h00);
    ovOpt = 1'b1;
    dev(6'h02, 8'h40);
    rd(`FSR_ADDR_DEV, 1'b0, 8'hFF, 8'h00);
    wp(3'h1);
    wp(3'h1);
    rd(`FSR_ADDR_DEV, 1'b1, 8'h0C, 8'h08);
    rd(`FSR_ADDR_DEV, 1'b0, 8'h0C, 8'h08);
    wp(3'h2);
    rd(`FSR_ADDR_DEV, 1'b0, 8'h0C, 8'h00);
    wp(3'h1);
    wp(3'h4);
    rd(`FSR_ADDR_DEV, 1'b0, 8'h0C, 8'h00);
    stopWd = 1'b1;
    wp(3'h1);
    wp(3'h4);
    rd(`FSR_ADDR_DEV, 1'b0, 8'h0C, 8'h04);
    stopWd = 1'b0;
    wp(3'h2);
    cfg = 3'h2;
    wp(3'h1);
    wp(3'h1);
    rd(`FSR_ADDR_DEV, 1'b0, 8'h0C, 8'h04);
    wp(3'h2);
    cfg = 3'h0;
    rd(`FSR_ADDR_DEV, 1'b1, 8'hFF, 8'h41);
    wd = 3'h1;
    tick(1);
    chk({7'h00, failPin}, 8'h00);
    wd = 3'h0;
    tick(1);
    rd(`FSR_ADDR_DEV, 1'b0, 8'h01, 8'h00);
    wd = 3'h1;
    tick(1);
    chk({7'h00, failPin}, 8'h01);
    wd = 3'h0;
    tick(1);
    rd(`FSR_ADDR_DEV, 1'b1, 8'h01, 8'h01);
    for (int i = 0; i < 3; i++) begin
      c = i[1:0] + 2'h1;
      bv = {2{3'h1 << i}};
      tick(14);
      bv = 6'h00;
      rd(`FSR_ADDR_BUS, 1'b1, 8'hFF, {1'b0, c, 2'b00, c, 1'b0});
    end
    canLow = 1'b1;
    tick(3);
    rd(`FSR_ADDR_BUS, 1'b0, 8'hFF, 8'h00);
    canMode = 1'b1;
    tick(2);
    chk({7'h00, canTxOff}, 8'h01);
    canLow = 1'b0;
    rd(`FSR_ADDR_BUS, 1'b1, 8'hFF, 8'h01);
    chk({7'h00, canTxOff}, 8'h00);
    rd(`FSR_ADDR_BUS, 1'b0, 8'hFF, 8'h00);
    // Soft reset drops sticky thermal flags
    th = 3'h7;
    tick(1);
    th = 3'h0;
    softReset = 1'b1;
    tick(1);
    softReset = 1'b0;
    rd(`FSR_ADDR_THERM, 1'b0, 8'hFF, 8'h00);
    summarize;
  end
endmodule // tb_fault_status_registers
